// ==== core/fpec_ctrl.v ====
// program/erase sequencer, protection check and charge pump control
`timescale 1ns/1ps
`include "fpec_defs.vh"

module fpec_ctrl #(
	parameter AW = 13
) (
	// clock and reset
	input  wire        i_core_clk,
	input  wire        i_srst,
	// processor memory bus
	input  wire [15:0] i_addr,
	input  wire        i_rd,
	input  wire        i_wr,
	input  wire [7:0]  i_wdata,
	output reg  [7:0]  o_rdata,
	// charge pump and array high-voltage switch
	output reg         o_pump_on,
	output reg         o_hv_to_array,
	// state visible to the rest of the chip
	output reg  [7:0]  o_osc_adjust,
	output reg  [7:0]  o_protect_start_byte
);

	reg [3:0]    ctrl_reg;
	reg [2:0]    state_reg;
	reg [2:0]    state_next;
	reg [AW-1:0] tgt_reg;
	reg [7:0]    prot_reg;
	reg [7:0]    trim_reg;
	wire         pgm_bit;
	wire         era_bit;
	wire         mass_bit;
	wire         high_voltage_enable_bit;
	wire [7:0]   arr_q;
	wire         in_array;
	wire         ctrl_wr;
	wire [3:0]   ctrl_w;
	reg  [3:0]   ctrl_next;
	wire         hv_ok;
	wire         prog_wr;
	wire         erase_go;
	wire [15:0]  tgt_full;

	assign pgm_bit  = ctrl_reg[`FPEC_BIT_PGM];
	assign era_bit  = ctrl_reg[`FPEC_BIT_ERASE];
	assign mass_bit = ctrl_reg[`FPEC_BIT_MASS];
	assign high_voltage_enable_bit = ctrl_reg[`FPEC_BIT_HIGH_VOLTAGE_ENABLE];
	assign ctrl_wr  = i_wr && (i_addr == `FPEC_CTRL_ADDR);
	assign ctrl_w   = i_wdata[3:0];

	// array occupies the top of the map; protect/trim bytes live there too
	function is_array;
		input [15:0] a;
		begin
			// the control register sits inside the array window; its writes must not latch or program
			is_array = (a >= `FPEC_ARRAY_BASE) && (a != `FPEC_CTRL_ADDR);
		end
	endfunction

	// protected range runs from 16'hc000 plus 64 times the protect byte's value up to the top
	function is_protected;
		input [15:0] a;
		input [7:0]  p;
		begin
			is_protected = (p != `FPEC_PROT_NONE) &&
				(a >= {2'b11, p, 6'h00});
		end
	endfunction

	// page match on full addresses, so erase reaches the protect and trim bytes
	function same_page;
		input [15:0] a;
		input [15:0] b;
		begin
			same_page = (a[15:`FPEC_PAGE_LSB] == b[15:`FPEC_PAGE_LSB]);
		end
	endfunction

	assign in_array = is_array(i_addr);
	// the array fills the top of the map, so the bits above the target are all ones
	assign tgt_full = {{(16-AW){1'b1}}, tgt_reg};

	////////////////////////////////////////////////////////////////////////
	// sequence tracker: select, protect read, latch write, high voltage

	always @* begin
		state_next = state_reg;
		case (state_reg)
			`FPEC_ST_IDLE: begin
				if (pgm_bit || era_bit)
					state_next = `FPEC_ST_SELECTED;
			end
			`FPEC_ST_SELECTED: begin
				if (i_rd && (i_addr == `FPEC_PROT_ADDR))
					state_next = `FPEC_ST_PROT_READ;
			end
			`FPEC_ST_PROT_READ: begin
				if (i_wr && in_array)
					state_next = `FPEC_ST_LATCHED;
			end
			`FPEC_ST_LATCHED: begin
				if (high_voltage_enable_bit)
					state_next = `FPEC_ST_HIGH_V;
			end
			`FPEC_ST_HIGH_V: begin
				if (!high_voltage_enable_bit)
					state_next = `FPEC_ST_IDLE;
			end
			default: state_next = `FPEC_ST_IDLE;
		endcase
		// dropping both selects outside high voltage restarts the sequence
		if (!pgm_bit && !era_bit && !high_voltage_enable_bit)
			state_next = `FPEC_ST_IDLE;
	end

	assign hv_ok = (pgm_bit || era_bit) && (state_reg == `FPEC_ST_LATCHED) &&
		!is_protected(tgt_full, prot_reg) &&
		!(era_bit && mass_bit && (prot_reg != `FPEC_PROT_NONE));

	always @* begin
		ctrl_next = ctrl_reg;
		if (ctrl_wr) begin
			// both selects at once is refused whole; one may not join the other
			if (ctrl_w[`FPEC_BIT_PGM] && ctrl_w[`FPEC_BIT_ERASE]) begin
				ctrl_next = ctrl_reg;
			end else begin
				ctrl_next[`FPEC_BIT_MASS] = ctrl_w[`FPEC_BIT_MASS];
				ctrl_next[`FPEC_BIT_PGM]  = ctrl_w[`FPEC_BIT_PGM] && !era_bit ?
					1'b1 : (ctrl_w[`FPEC_BIT_PGM] ? pgm_bit : 1'b0);
				ctrl_next[`FPEC_BIT_ERASE] = ctrl_w[`FPEC_BIT_ERASE] && !pgm_bit ?
					1'b1 : (ctrl_w[`FPEC_BIT_ERASE] ? era_bit : 1'b0);
				if (!ctrl_w[`FPEC_BIT_HIGH_VOLTAGE_ENABLE])
					ctrl_next[`FPEC_BIT_HIGH_VOLTAGE_ENABLE] = 1'b0;
				else if (!high_voltage_enable_bit)
					ctrl_next[`FPEC_BIT_HIGH_VOLTAGE_ENABLE] = hv_ok;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// registers

	always @(posedge i_core_clk) begin
		if (i_srst) begin
			ctrl_reg  <= `FPEC_CTRL_RST;
			state_reg <= `FPEC_ST_IDLE;
			tgt_reg   <= {AW{1'b0}};
		end else begin
			ctrl_reg  <= ctrl_next;
			state_reg <= state_next;
			// latch the target of the first array write after the protect read
			if ((state_reg == `FPEC_ST_PROT_READ) && i_wr && in_array)
				tgt_reg <= i_addr[AW-1:0];
		end
	end

	// protect and trim bytes are array contents, so reset leaves them alone
	always @(posedge i_core_clk) begin
		prot_reg <= (i_addr == `FPEC_PROT_ADDR) && prog_wr ? (prot_reg & i_wdata) :
			(erase_go && (mass_bit || same_page(tgt_full, `FPEC_PROT_ADDR)) ? `FPEC_ERASED_BYTE : prot_reg);
		trim_reg <= (i_addr == `FPEC_TRIM_ADDR) && prog_wr ? (trim_reg & i_wdata) :
			(erase_go && (mass_bit || same_page(tgt_full, `FPEC_TRIM_ADDR)) ? `FPEC_ERASED_BYTE : trim_reg);
	end

	////////////////////////////////////////////////////////////////////////
	// array operations under high voltage

	// program writes stay in the latched row and outside the protected range
	assign prog_wr = high_voltage_enable_bit && pgm_bit && i_wr && in_array &&
		(i_addr[AW-1:`FPEC_ROW_LSB] == tgt_reg[AW-1:`FPEC_ROW_LSB]) &&
		!is_protected(i_addr, prot_reg);
	// erase pulse on the cycle high voltage turns on
	assign erase_go = era_bit && (state_reg == `FPEC_ST_LATCHED) && high_voltage_enable_bit;

	fpec_array #(
		.AW (AW)
	) u_array (
		.i_core_clk   (i_core_clk),
		.i_rd_addr    (i_addr[AW-1:0]),
		.o_rd_data    (arr_q),
		.i_erase_en   (erase_go),
		.i_mass       (mass_bit),
		.i_erase_addr (tgt_reg),
		.i_prog_en    (prog_wr),
		.i_prog_addr  (i_addr[AW-1:0]),
		.i_prog_data  (i_wdata)
	);

	////////////////////////////////////////////////////////////////////////
	// outputs, all registered

	always @(posedge i_core_clk) begin
		if (i_srst) begin
			o_rdata              <= 8'h00;
			o_pump_on            <= 1'b0;
			o_hv_to_array        <= 1'b0;
			o_osc_adjust         <= `FPEC_ERASED_BYTE;
			o_protect_start_byte <= `FPEC_PROT_NONE;
		end else begin
			o_pump_on            <= ctrl_next[`FPEC_BIT_HIGH_VOLTAGE_ENABLE];
			o_hv_to_array        <= ctrl_next[`FPEC_BIT_HIGH_VOLTAGE_ENABLE];
			o_osc_adjust         <= trim_reg;
			o_protect_start_byte <= prot_reg;
			if (i_addr == `FPEC_CTRL_ADDR)
				o_rdata <= {4'h0, ctrl_reg};
			else if (i_addr == `FPEC_PROT_ADDR)
				o_rdata <= prot_reg;
			else if (i_addr == `FPEC_TRIM_ADDR)
				o_rdata <= trim_reg;
			else if (in_array)
				o_rdata <= arr_q;
			else
				o_rdata <= 8'h00;
		end
	end

endmodule

// ==== core/fpec_defs.vh ====
// constants for the nonvolatile program/erase control block
`ifndef FPEC_DEFS_VH
`define FPEC_DEFS_VH

// register addresses
`define FPEC_CTRL_ADDR      16'hfe08
`define FPEC_PROT_ADDR      16'hffbe
`define FPEC_TRIM_ADDR      16'hffc0
`define FPEC_ARRAY_BASE     16'he000

// control register bit positions
`define FPEC_BIT_PGM        0
`define FPEC_BIT_ERASE      1
`define FPEC_BIT_MASS       2
`define FPEC_BIT_HIGH_VOLTAGE_ENABLE       3

// reset values
`define FPEC_CTRL_RST       4'h0
`define FPEC_ERASED_BYTE    8'hff
`define FPEC_PROT_NONE      8'hff

// geometry
`define FPEC_PAGE_BYTES     64
`define FPEC_ROW_BYTES      32
`define FPEC_PAGE_LSB       6
`define FPEC_ROW_LSB        5

// sequence states
`define FPEC_ST_IDLE        3'h0
`define FPEC_ST_SELECTED    3'h1
`define FPEC_ST_PROT_READ   3'h2
`define FPEC_ST_LATCHED     3'h3
`define FPEC_ST_HIGH_V      3'h4

`endif

// ==== core/fpec_array.v ====
// nonvolatile array storage model with page erase and byte program
`timescale 1ns/1ps
`include "fpec_defs.vh"

module fpec_array #(
	parameter AW = 13
) (
	// clock; no reset input
	input  wire          i_core_clk,
	// read port
	input  wire [AW-1:0] i_rd_addr,
	output wire [7:0]    o_rd_data,
	// page erase
	input  wire          i_erase_en,
	input  wire          i_mass,
	input  wire [AW-1:0] i_erase_addr,
	// byte program
	input  wire          i_prog_en,
	input  wire [AW-1:0] i_prog_addr,
	input  wire [7:0]    i_prog_data
);

	localparam DEPTH = 1 << AW;

	reg [7:0] cell_reg [0:DEPTH-1];
	integer   k;

	// erased cells hold ones; programming can only clear bits
	assign o_rd_data = cell_reg[i_rd_addr];

	always @(posedge i_core_clk) begin
		for (k = 0; k < DEPTH; k = k + 1) begin
			if (i_erase_en && (i_mass ||
				(k[AW-1:`FPEC_PAGE_LSB] == i_erase_addr[AW-1:`FPEC_PAGE_LSB]))) begin
				cell_reg[k] <= `FPEC_ERASED_BYTE;
			end else if (i_prog_en && (k[AW-1:0] == i_prog_addr)) begin
				cell_reg[k] <= cell_reg[k] & i_prog_data;
			end
		end
	end

endmodule

// ==== testbench/fpec_ctrl_monitor.sv ====
// port checks for the program/erase control block
`timescale 1ns/1ps
`include "fpec_defs.vh"
module fpec_mon (
	input wire        i_core_clk,
	input wire        i_srst,
	input wire [15:0] i_addr,
	input wire        i_rd,
	input wire        i_wr,
	input wire [7:0]  i_wdata,
	input wire [7:0]  o_rdata,
	input wire        o_pump_on,
	input wire        o_hv_to_array,
	input wire [7:0]  o_osc_adjust,
	input wire [7:0]  o_protect_start_byte
);
	wire       cw = i_wr && i_addr == `FPEC_CTRL_ADDR;
	wire       clr = cw && !i_wdata[3];
	wire       hv_w = cw && i_wdata[3];
	reg [15:0] lat_reg;
	reg        seen_reg;
	// last array target before high voltage; the protect check is made against it
	always @(posedge i_core_clk) begin
		if (i_srst || clr)
			seen_reg <= 1'b0;
		else if (i_rd && i_addr == `FPEC_PROT_ADDR)
			seen_reg <= 1'b1;
		if (i_wr && !cw && i_addr >= `FPEC_ARRAY_BASE && !o_pump_on)
			lat_reg <= i_addr;
	end
	////////////////////////////////////////
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_srst);
	a_hv_cause: assert property ($rose(o_pump_on) |-> $past(hv_w) || $past(hv_w, 2))
		else $error("pump rose without a control write");
	// an erased protect byte protects nothing
	a_hv_prot: assert property ($rose(o_pump_on) |->
		(o_protect_start_byte == `FPEC_PROT_NONE) || (lat_reg < {2'b11, o_protect_start_byte, 6'h00}))
		else $error("pump rose on a protected target");
	a_hv_seq: assert property ($rose(o_pump_on) |-> seen_reg)
		else $error("pump rose without protect read");
	a_pump_pair: assert property (o_pump_on == o_hv_to_array)
		else $error("pump and array switch differ");
	a_sel_excl: assert property (i_addr == `FPEC_CTRL_ADDR |=> o_rdata[1:0] != 2'b11)
		else $error("both selects read as set");
	a_pump_drop: assert property (clr |-> ##[1:2] !o_pump_on)
		else $error("pump stayed on after clear");
	a_pump_stand: assert property (o_pump_on && !clr && !$past(clr) |=> o_pump_on)
		else $error("pump dropped by itself");
	// read data and the copy are loaded at the same edge, so compare them side by side
	a_prot_read: assert property (i_addr == `FPEC_PROT_ADDR |=> o_rdata == o_protect_start_byte)
		else $error("protect byte read wrong");
	cover property ($rose(o_pump_on));
	cover property (clr && o_pump_on);
	cover property (i_rd && i_addr == `FPEC_PROT_ADDR);
endmodule
bind fpec_ctrl fpec_mon u_fpec_mon (.i_core_clk, .i_srst, .i_addr, .i_rd, .i_wr, .i_wdata, .o_rdata,
	.o_pump_on, .o_hv_to_array, .o_osc_adjust, .o_protect_start_byte);

// ==== testbench/fpec_cpu.sv ====
// processor core model issuing memory bus accesses
`timescale 1ns/1ps
`include "fpec_defs.vh"
module fpec_cpu (
	input  wire        i_core_clk,
	input  wire [7:0]  i_rdata,
	output reg  [15:0] o_addr,
	output reg         o_rd,
	output reg         o_wr,
	output reg  [7:0]  o_wdata
);
	initial begin
		o_addr = 16'h0000;
		o_rd = 1'b0;
		o_wr = 1'b0;
		o_wdata = 8'h00;
	end
	// idle data shows the inverse so a stale byte cannot pass
	task wr(input [15:0] a, input [7:0] d);
		@(negedge i_core_clk);
		o_addr = a;
		o_wdata = d;
		o_wr = 1'b1;
		@(negedge i_core_clk);
		o_wr = 1'b0;
		o_wdata = ~d;
	endtask
	task rd(input [15:0] a, output [7:0] q);
		@(negedge i_core_clk);
		o_addr = a;
		o_rd = 1'b1;
		@(negedge i_core_clk);
		o_rd = 1'b0;
		q = i_rdata;
	endtask
	// chk low skips the protect read on purpose
	task arm(input [7:0] sel, input [15:0] tgt, input chk);
		reg [7:0] q;
		wr(`FPEC_CTRL_ADDR, sel);
		if (chk)
			rd(`FPEC_PROT_ADDR, q);
		wr(tgt, 8'h00);
		wr(`FPEC_CTRL_ADDR, sel | 8'h08);
	endtask
	task done;
		wr(`FPEC_CTRL_ADDR, 8'h08);
		wr(`FPEC_CTRL_ADDR, 8'h00);
	endtask
endmodule

// ==== testbench/fpec_ctrl_test.sv ====
// scenarios for the program/erase control block
`timescale 1ns/1ps
`include "fpec_defs.vh"
module fpec_ctrl_test;
	reg         i_core_clk = 1'b0;
	reg         i_srst = 1'b1;
	wire [15:0] i_addr;
	wire        i_rd;
	wire        i_wr;
	wire [7:0]  i_wdata;
	wire [7:0]  o_rdata;
	wire        o_pump_on;
	wire        o_hv_to_array;
	wire [7:0]  o_osc_adjust;
	wire [7:0]  o_protect_start_byte;
	integer     errors = 0;
	integer     comparisons = 0;
	reg  [7:0]  q;
	always #10 i_core_clk = ~i_core_clk;
	fpec_ctrl u_fpec_ctrl (.i_core_clk, .i_srst, .i_addr, .i_rd, .i_wr, .i_wdata, .o_rdata, .o_pump_on,
		.o_hv_to_array, .o_osc_adjust, .o_protect_start_byte);
	fpec_cpu u_fpec_cpu (.i_core_clk, .i_rdata(o_rdata), .o_addr(i_addr), .o_rd(i_rd), .o_wr(i_wr),
		.o_wdata(i_wdata));
	////////////////////////////////////////
	task check(input [7:0] seen, input [7:0] exp);
		comparisons = comparisons + 1;
		if (seen !== exp) begin
			errors = errors + 1;
			$display("ERROR %0t saw %h expected %h", $time, seen, exp);
		end
	endtask
	task look(input [15:0] a, input [7:0] exp);
		u_fpec_cpu.rd(a, q);
		check(q, exp);
	endtask
	task hv(input e);
		@(negedge i_core_clk);
		check({6'h00, o_hv_to_array, o_pump_on}, {6'h00, e, e});
	endtask
	task results;
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		#200000;
		errors = errors + 1;
		results;
	end
	initial begin
		// blank part: the protect byte starts erased and reset leaves it alone
		u_fpec_ctrl.prot_reg = `FPEC_PROT_NONE;
		repeat (10) @(negedge i_core_clk);
		i_srst = 1'b0;
		hv(1'b0);
		u_fpec_cpu.wr(`FPEC_CTRL_ADDR, 8'h03);
		look(`FPEC_CTRL_ADDR, 8'h00);
		u_fpec_cpu.wr(`FPEC_CTRL_ADDR, 8'h01);
		u_fpec_cpu.wr(`FPEC_CTRL_ADDR, 8'h03);
		look(`FPEC_CTRL_ADDR, 8'h01);
		u_fpec_cpu.wr(`FPEC_CTRL_ADDR, 8'h02);
		look(`FPEC_CTRL_ADDR, 8'h00);
		u_fpec_cpu.wr(`FPEC_CTRL_ADDR, 8'h08);
		hv(1'b0);
		u_fpec_cpu.arm(8'h01, 16'he040, 1'b0);
		hv(1'b0);
		u_fpec_cpu.done;
		u_fpec_cpu.arm(8'h06, 16'he000, 1'b1);
		hv(1'b1);
		u_fpec_cpu.done;
		look(16'he000, 8'hff);
		u_fpec_cpu.arm(8'h01, 16'he05f, 1'b1);
		hv(1'b1);
		u_fpec_cpu.wr(16'he040, 8'h5a);
		u_fpec_cpu.wr(16'he03f, 8'h00);
		u_fpec_cpu.done;
		look(16'he040, 8'h5a);
		look(16'he03f, 8'hff);
		for (int p = 0; p < 2; p++) begin
			u_fpec_cpu.arm(8'h02, p ? 16'he07f : 16'he000, 1'b1);
			hv(1'b1);
			u_fpec_cpu.done;
			look(16'he040, p ? 8'hff : 8'h5a);
		end
		u_fpec_cpu.arm(8'h01, 16'hffc0, 1'b1);
		u_fpec_cpu.wr(`FPEC_TRIM_ADDR, 8'h3c);
		u_fpec_cpu.done;
		look(`FPEC_TRIM_ADDR, 8'h3c);
		check(o_osc_adjust, 8'h3c);
		u_fpec_cpu.arm(8'h02, 16'hffc5, 1'b1);
		hv(1'b1);
		u_fpec_cpu.done;
		check(o_osc_adjust, `FPEC_ERASED_BYTE);
		u_fpec_cpu.arm(8'h01, 16'hffa0, 1'b1);
		u_fpec_cpu.wr(`FPEC_PROT_ADDR, 8'h80);
		u_fpec_cpu.done;
		look(`FPEC_PROT_ADDR, 8'h80);
		check(o_protect_start_byte, 8'h80);
		u_fpec_cpu.arm(8'h02, 16'he040, 1'b1);
		hv(1'b0);
		u_fpec_cpu.done;
		u_fpec_cpu.arm(8'h06, 16'he000, 1'b1);
		hv(1'b0);
		u_fpec_cpu.done;
		results;
	end
endmodule
